// ===== hw/fom_regs.svh
// constants for the fsk/ook modem datapath: offsets, fields, reset values, counts
// assumes a 32-bit plain register port with word offsets
`ifndef FOM_REGS_SVH
`define FOM_REGS_SVH
`define FOM_ADDR_W          8
`define FOM_OFF_DEV         8'h00
`define FOM_OFF_RATE        8'h04
`define FOM_OFF_SHAPE       8'h08
`define FOM_OFF_OOK         8'h0c
`define FOM_OFF_RXCFG       8'h10
`define FOM_OFF_CARRIER     8'h14
`define FOM_OFF_BW          8'h18
`define FOM_OFF_FEI         8'h1c
`define FOM_OFF_STATUS      8'h20
`define FOM_OFF_CTRL        8'h24
`define FOM_RATE_RST        20'h682b0
`define FOM_DEV_RST         14'h0052
`define FOM_OOK_FLOOR_RST   8'h0c
`define FOM_OOK_STEP_RST    3'h0
`define FOM_OOK_DEC_RST     3'h0
`define FOM_CARRIER_RST     24'he4c000
`define FOM_FEI_BITS        3'h4
`define FOM_PEAK_DROP       8'h0c
`define FOM_SYNC_TOL        5'h10
`endif

// ===== hw/fom_pkg.sv
// types for the fsk/ook modem datapath
// assumes fom_regs.svh holds the numeric constants
package fom_pkg;
	typedef enum logic [1:0] {
		FOM_THR_FIXED = 2'b00,
		FOM_THR_PEAK  = 2'b01,
		FOM_THR_AVG   = 2'b10
	} fom_thr_t;
	typedef enum logic [1:0] {
		FOM_AFC_IDLE = 2'b00,
		FOM_AFC_WAIT = 2'b01,
		FOM_AFC_MEAS = 2'b10,
		FOM_AFC_DONE = 2'b11
	} fom_afc_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} fom_bus_t;
	typedef struct packed {
		logic       rx_mode;
		logic       tx_mode;
		logic       ook_mode;
		logic       packet_mode;
		logic       preamble_found_flag;
		logic [7:0] rssi;
		logic       fsk_bit;
		logic [7:0] freq_disc;
	} fom_rf_t;
endpackage

// ===== hw/fom_datapath.sv
// fsk/ook modem datapath: deviation, shaping, tx pacing, ook slicer, bit sync, fei, afc
// assumes analog front end gives rssi, demodulated bit and signed discriminator on core_clk
// Overview of operation
// - deviation is synth step times deviation field
// - ook keys amplifier, ramps bias if shaped
// - fsk shaped stream through gaussian filter
// - bit clock pulses per bit; host supplies (transmit clock only given when shaping is on)
// - ook slicer has peak, fixed, average modes
// - peak mode threshold is peak minus 6dB
// - peak decays per step, floored at level
// - fixed uses floor; average uses running mean
// - continuous rx gives retimed data and clock
// - synchronizer forced on in packet mode
// - fei measures 4 bits, signed result stored
// - fei starts on rx entry, every 4 bits
// - afc subtracts correction from carrier setting
// - clear option corrects from original centre
// - correction bandwidth during afc, channel after
// - preamble gated start triggers on preamble flag
// - bit rate is crystal over rate plus fraction (fraction dropped in ook)
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "fom_regs.svh"
module fom_datapath (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire fom_pkg::fom_bus_t bus,
	output      logic [31:0]       rdata,
	input  wire fom_pkg::fom_rf_t  rf,
	input  wire logic              tx_data_in,
	output      logic [23:0]       synth_frac,
	output      logic [7:0]        pa_level,
	output      logic [7:0]        rx_bw,
	output      logic              bit_clock_out,
	output      logic              rx_data_out
);
	import fom_pkg::*;

	// ---------------- registers ----------------
	logic [13:0] freq_deviation_field;
	logic [19:0] rate_reg;               // {rate_high_byte, rate_low_byte, rate_fraction}
	logic [1:0]  pa_ramp_shaping_field;  // 0 none, 1 bt1.0, 2 bt0.5
	logic [1:0]  ook_threshold_type;
	logic [2:0]  peak_decrement_step;
	logic [2:0]  peak_decrement_period;
	logic [7:0]  ook_floor_level;
	logic        auto_correction_enable;
	logic        correction_clear_enable;
	logic        preamble_gated_start;
	logic        sync_disable;
	logic        continuous_mode;
	logic [23:0] carrier_freq_setting;
	logic [7:0]  channel_bw_reg;
	logic [7:0]  correction_bw_reg;
	logic [15:0] freq_error_value;
	logic [15:0] freq_correction_value;
	logic [23:0] carrier_base;

	logic [7:0]  addr_s;
	assign addr_s = bus.addr;

	// afc write-back to carrier uses these
	logic        afc_apply;
	logic [23:0] next_carrier;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			freq_deviation_field    <= `FOM_DEV_RST;
			rate_reg                <= `FOM_RATE_RST;
			pa_ramp_shaping_field   <= 2'h0;
			ook_threshold_type      <= 2'h1;
			peak_decrement_step     <= `FOM_OOK_STEP_RST;
			peak_decrement_period   <= `FOM_OOK_DEC_RST;
			ook_floor_level         <= `FOM_OOK_FLOOR_RST;
			auto_correction_enable  <= 1'b0;
			correction_clear_enable <= 1'b0;
			preamble_gated_start    <= 1'b0;
			sync_disable            <= 1'b0;
			continuous_mode         <= 1'b0;
			carrier_base            <= `FOM_CARRIER_RST;
			channel_bw_reg          <= 8'h15;
			correction_bw_reg       <= 8'h0b;
		end else if (bus.wr) begin
			if (addr_s == `FOM_OFF_DEV) begin
				freq_deviation_field <= bus.wdata[13:0];
			end else if (addr_s == `FOM_OFF_RATE) begin
				rate_reg <= bus.wdata[19:0];
			end else if (addr_s == `FOM_OFF_SHAPE) begin
				pa_ramp_shaping_field <= bus.wdata[1:0];
			end else if (addr_s == `FOM_OFF_OOK) begin
				ook_floor_level       <= bus.wdata[7:0];
				peak_decrement_step   <= bus.wdata[10:8];
				peak_decrement_period <= bus.wdata[13:11];
				ook_threshold_type    <= bus.wdata[15:14];
			end else if (addr_s == `FOM_OFF_RXCFG) begin
				auto_correction_enable  <= bus.wdata[0];
				correction_clear_enable <= bus.wdata[1];
				preamble_gated_start    <= bus.wdata[2];
				sync_disable            <= bus.wdata[3];
				continuous_mode         <= bus.wdata[4];
			end else if (addr_s == `FOM_OFF_CARRIER) begin
				carrier_base <= bus.wdata[23:0];
			end else if (addr_s == `FOM_OFF_BW) begin
				channel_bw_reg    <= bus.wdata[7:0];
				correction_bw_reg <= bus.wdata[15:8];
			end
		end
	end

	// carrier: software write sets both centre and working value; afc adjusts working
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			carrier_freq_setting <= `FOM_CARRIER_RST;
		end else if (bus.wr && addr_s == `FOM_OFF_CARRIER) begin
			carrier_freq_setting <= bus.wdata[23:0];
		end else if (afc_apply) begin
			carrier_freq_setting <= next_carrier;
		end
	end

	// ---------------- bit rate timing ----------------
	// period in 1/16 clock: rate*16 + fraction; fraction dropped in ook
	logic [19:0] period_x16;
	logic [19:0] phase_acc;
	logic        bit_tick;
	assign period_x16 = {rate_reg[19:4], (rf.ook_mode ? 4'h0 : rate_reg[3:0])};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_acc <= 20'h0;
			bit_tick  <= 1'b0;
		end else if (phase_acc + 20'h10 >= period_x16) begin
			phase_acc <= phase_acc + 20'h10 - period_x16;
			bit_tick  <= 1'b1;
		end else begin
			phase_acc <= phase_acc + 20'h10;
			bit_tick  <= 1'b0;
		end
	end

	// ---------------- transmit ----------------
	logic [1:0]  tx_in_s;
	logic [3:0]  tx_hist;
	logic [13:0] shaped_dev;
	logic        tx_bit;
	assign tx_bit = tx_hist[0];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_in_s <= 2'h0;
		end else begin
			tx_in_s <= {tx_in_s[0], tx_data_in};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_hist <= 4'h0;
		end else if (rf.tx_mode && bit_tick) begin
			tx_hist <= {tx_hist[2:0], tx_in_s[1]};
		end
	end

	// gaussian approximation: bt1 short 3-tap, bt0.5 wider 4-tap, weights in quarters
	function automatic logic [2:0] fom_taps(input logic [3:0] h, input logic [1:0] sel);
		logic [2:0] s;
		s = 3'h0;
		if (sel == 2'h1) begin
			s = {2'b00, h[0]} + {1'b0, h[1], 1'b0} + {2'b00, h[2]};
		end else begin
			s = {2'b00, h[0]} + {2'b00, h[1]} + {2'b00, h[2]} + {2'b00, h[3]};
		end
		return s;
	endfunction

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shaped_dev <= 14'h0;
		end else if (pa_ramp_shaping_field == 2'h0) begin
			shaped_dev <= freq_deviation_field;
		end else begin
			shaped_dev <= 14'((28'(freq_deviation_field) * 28'(fom_taps(tx_hist,
				pa_ramp_shaping_field))) >> 2);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			synth_frac <= 24'h0;
		end else if (rf.tx_mode && !rf.ook_mode) begin
			if (pa_ramp_shaping_field == 2'h0) begin
				synth_frac <= tx_bit ? carrier_freq_setting + 24'(freq_deviation_field)
				                     : carrier_freq_setting - 24'(freq_deviation_field);
			end else begin
				synth_frac <= carrier_freq_setting - 24'(freq_deviation_field)
				              + 24'({shaped_dev, 1'b0});
			end
		end else begin
			synth_frac <= carrier_freq_setting;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pa_level <= 8'h0;
		end else if (!rf.tx_mode) begin
			pa_level <= 8'h0;
		end else if (!rf.ook_mode) begin
			pa_level <= 8'hff;
		end else if (pa_ramp_shaping_field == 2'h0) begin
			pa_level <= tx_bit ? 8'hff : 8'h00;
		end else if (tx_bit && pa_level != 8'hff) begin
			pa_level <= pa_level + 8'h01;
		end else if (!tx_bit && pa_level != 8'h00) begin
			pa_level <= pa_level - 8'h01;
		end
	end

	// ---------------- ook slicer ----------------
	logic [7:0] peak;
	logic [7:0] avg;
	logic [7:0] ook_thr;
	logic [7:0] dec_cnt;
	logic       ook_bit;
	logic [8:0] peak_low;
	// nine bits so a high floor plus step cannot wrap the compare
	assign peak_low = {1'b0, ook_floor_level} + {6'h0, peak_decrement_step} + 9'h001;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dec_cnt <= 8'h0;
			peak    <= 8'h0;
		end else if (rf.rssi > peak) begin
			peak    <= rf.rssi;
			dec_cnt <= 8'h0;
		end else if (!ook_bit && bit_tick) begin
			if (dec_cnt >= {5'h0, peak_decrement_period}) begin
				dec_cnt <= 8'h0;
				peak <= ({1'b0, peak} > peak_low)
				        ? peak - {5'h0, peak_decrement_step} - 8'h01 : ook_floor_level;
			end else begin
				dec_cnt <= dec_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avg <= 8'h0;
		end else begin
			avg <= avg - (avg >> 3) + (rf.rssi >> 3);
		end
	end

	always_comb begin
		ook_thr = ook_floor_level;
		if (ook_threshold_type == FOM_THR_PEAK) begin
			ook_thr = (peak > `FOM_PEAK_DROP) ? peak - `FOM_PEAK_DROP : 8'h0;
		end else if (ook_threshold_type == FOM_THR_AVG) begin
			ook_thr = avg;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ook_bit <= 1'b0;
		end else begin
			ook_bit <= rf.rssi > ook_thr;
		end
	end

	// ---------------- bit synchronizer ----------------
	logic [19:0] sync_acc;
	logic        demod_bit;
	logic        demod_prev;
	logic        sync_on;
	assign demod_bit = rf.ook_mode ? ook_bit : rf.fsk_bit;
	assign sync_on   = rf.packet_mode || !sync_disable;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_acc    <= 20'h0;
			demod_prev  <= 1'b0;
			rx_data_out <= 1'b0;
		end else begin
			demod_prev <= demod_bit;
			if (demod_bit != demod_prev) begin
				sync_acc <= {1'b0, period_x16[19:1]}; // realign mid-bit on edges
			end else if (sync_acc + 20'h10 >= period_x16) begin
				sync_acc <= sync_acc + 20'h10 - period_x16;
			end else begin
				sync_acc <= sync_acc + 20'h10;
			end
			if (!sync_on) begin
				rx_data_out <= demod_bit;
			end else if (sync_acc + 20'h10 >= period_x16) begin
				rx_data_out <= demod_bit;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bit_clock_out <= 1'b0;
		end else if (rf.rx_mode && continuous_mode && sync_on) begin
			bit_clock_out <= sync_acc >= {1'b0, period_x16[19:1]};
		end else if (rf.tx_mode && continuous_mode && pa_ramp_shaping_field != 2'h0) begin
			bit_clock_out <= bit_tick;
		end else begin
			bit_clock_out <= 1'b0;
		end
	end

	// ---------------- fei / afc ----------------
	fom_afc_t    afc_state;
	logic [2:0]  fei_bits;
	logic [17:0] fei_sum;
	logic        rx_prev;
	logic        rx_rise;
	assign rx_rise = rf.rx_mode && !rx_prev;
	logic [17:0] fei_next;
	logic [15:0] fei_avg;
	assign fei_next = fei_sum + {{10{rf.freq_disc[7]}}, rf.freq_disc};
	assign fei_avg  = 16'(signed'(fei_next) >>> 2);
	assign next_carrier = (correction_clear_enable ? carrier_base : carrier_freq_setting)
	                      - 24'(signed'(freq_correction_value));
	assign afc_apply = afc_state == FOM_AFC_DONE && auto_correction_enable;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_prev               <= 1'b0;
			afc_state             <= FOM_AFC_IDLE;
			fei_bits              <= 3'h0;
			fei_sum               <= 18'h0;
			freq_error_value      <= 16'h0;
			freq_correction_value <= 16'h0;
		end else begin
			rx_prev <= rf.rx_mode;
			case (afc_state)
				FOM_AFC_IDLE: begin
					if (rx_rise) begin
						afc_state <= preamble_gated_start ? FOM_AFC_WAIT : FOM_AFC_MEAS;
					end
				end
				FOM_AFC_WAIT: begin
					if (rf.preamble_found_flag) begin
						afc_state <= FOM_AFC_MEAS;
					end
				end
				FOM_AFC_MEAS: begin
					if (bit_tick) begin
						if (fei_bits == `FOM_FEI_BITS - 3'h1) begin
							fei_bits              <= 3'h0;
							fei_sum               <= 18'h0;
							freq_error_value      <= fei_avg;
							freq_correction_value <= auto_correction_enable ? fei_avg : 16'h0;
							afc_state             <= FOM_AFC_DONE;
						end else begin
							fei_sum  <= fei_next;
							fei_bits <= fei_bits + 3'h1;
						end
					end
				end
				FOM_AFC_DONE: begin
					afc_state <= rf.rx_mode ? FOM_AFC_MEAS : FOM_AFC_IDLE;
				end
				default: afc_state <= FOM_AFC_IDLE;
			endcase
			// a cut measurement must not leak into the next receive period
			if (!rf.rx_mode) begin
				afc_state <= FOM_AFC_IDLE;
				fei_bits  <= 3'h0;
				fei_sum   <= 18'h0;
			end
		end
	end

	// correction bandwidth until first correction of this receive period
	logic afc_done_once;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			afc_done_once <= 1'b0;
			rx_bw         <= 8'h0;
		end else begin
			if (!rf.rx_mode) begin
				afc_done_once <= 1'b0;
			end else if (afc_state == FOM_AFC_DONE) begin
				afc_done_once <= 1'b1;
			end
			rx_bw <= (auto_correction_enable && !afc_done_once) ? correction_bw_reg
			                                                     : channel_bw_reg;
		end
	end

	// ---------------- read port ----------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0;
		end else if (!bus.rd) begin
			rdata <= 32'h0;
		end else if (addr_s == `FOM_OFF_DEV) begin
			rdata <= {18'h0, freq_deviation_field};
		end else if (addr_s == `FOM_OFF_RATE) begin
			rdata <= {12'h0, rate_reg};
		end else if (addr_s == `FOM_OFF_SHAPE) begin
			rdata <= {30'h0, pa_ramp_shaping_field};
		end else if (addr_s == `FOM_OFF_OOK) begin
			rdata <= {16'h0, ook_threshold_type, peak_decrement_period,
			          peak_decrement_step, ook_floor_level};
		end else if (addr_s == `FOM_OFF_RXCFG) begin
			rdata <= {27'h0, continuous_mode, sync_disable, preamble_gated_start,
			          correction_clear_enable, auto_correction_enable};
		end else if (addr_s == `FOM_OFF_CARRIER) begin
			rdata <= {8'h0, carrier_freq_setting};
		end else if (addr_s == `FOM_OFF_BW) begin
			rdata <= {16'h0, correction_bw_reg, channel_bw_reg};
		end else if (addr_s == `FOM_OFF_FEI) begin
			rdata <= {freq_correction_value, freq_error_value};
		end else if (addr_s == `FOM_OFF_STATUS) begin
			rdata <= {16'h0, peak, 4'h0, afc_done_once, ook_bit, afc_state};
		end else begin
			rdata <= 32'h0;
		end
	end

	// ---------------- assertions ----------------
	sequence s_meas_end;
		afc_state == FOM_AFC_MEAS && bit_tick && fei_bits == 3'h3 && rf.rx_mode;
	endsequence

	a_fei_result: assert property (@(posedge core_clk) disable iff (rst)
		s_meas_end |=> afc_state == FOM_AFC_DONE)
		else $error("fei did not finish after four bits");
	a_fei_restart: assert property (@(posedge core_clk) disable iff (rst)
		afc_state == FOM_AFC_DONE && rf.rx_mode |=> afc_state == FOM_AFC_MEAS)
		else $error("fei not refreshed");
	a_gated_wait: assert property (@(posedge core_clk) disable iff (rst)
		afc_state == FOM_AFC_WAIT && !rf.preamble_found_flag && rf.rx_mode
		|=> afc_state == FOM_AFC_WAIT)
		else $error("measurement started without preamble");
	a_afc_apply: assert property (@(posedge core_clk) disable iff (rst)
		afc_apply && !bus.wr |=> carrier_freq_setting == $past(next_carrier))
		else $error("correction not applied to carrier");
	a_peak_floor: assert property (@(posedge core_clk) disable iff (rst)
		peak >= ook_floor_level && rf.rssi <= peak && !bus.wr |=> peak >= ook_floor_level)
		else $error("peak fell below floor");
	a_fixed_thr: assert property (@(posedge core_clk) disable iff (rst)
		ook_threshold_type == FOM_THR_FIXED |=> ook_bit == ($past(rf.rssi) > $past(ook_floor_level)))
		else $error("fixed slicer wrong");
	a_peak_thr: assert property (@(posedge core_clk) disable iff (rst)
		ook_threshold_type == FOM_THR_PEAK && peak > 8'h0c |-> ook_thr == peak - 8'h0c)
		else $error("peak threshold not 6dB below");
	a_bw_select: assert property (@(posedge core_clk) disable iff (rst)
		auto_correction_enable && !afc_done_once && !bus.wr ##1 !bus.wr
		|-> rx_bw == correction_bw_reg)
		else $error("afc bandwidth not used");
	a_tx_clock: assert property (@(posedge core_clk) disable iff (rst)
		rf.tx_mode && continuous_mode && pa_ramp_shaping_field != 2'h0 && bit_tick
		|=> bit_clock_out)
		else $error("no bit clock for transmit bit");
endmodule // fom_datapath

// ===== tb/fom_mcu_model.sv
// companion controller model: feeds continuous-mode transmit bits
// assumes bit_clock_out pulses for one core_clk cycle per bit wanted
`timescale 1ns/10ps
module fom_mcu_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       bit_clock_out,
	input  wire logic [1:0] pattern,
	output      logic       tx_data_in
);
	logic [7:0] shift;

	// pattern 0 alternates, 1 holds ones, 2 holds zeros
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift      <= 8'h55;
			tx_data_in <= 1'b0;
		end else if (bit_clock_out) begin
			shift      <= {shift[6:0], shift[7]};
			tx_data_in <= (pattern == 2'h0) ? shift[7] : (pattern == 2'h1);
		end else if (pattern != 2'h0) begin
			tx_data_in <= (pattern == 2'h1);
		end
	end
endmodule // fom_mcu_model

// ===== tb/fom_datapath_test.sv
// self-checking bench for the fsk/ook modem datapath
// assumes the offsets of fom_regs.svh and a 125 MHz core clock
`timescale 1ns/10ps
`include "fom_regs.svh"
module fom_datapath_test;
	import fom_pkg::*;
	// 250 kbit/s keeps deviation plus half the rate legal
	localparam int rate = 500;
	logic        core_clk   = 1'b0;
	logic        rst        = 1'b1;
	fom_bus_t    bus        = '0;
	fom_rf_t     rf         = '0;
	logic [1:0]  pattern    = 2'h1;
	logic        rx_alt     = 1'b0;
	logic [31:0] seed       = 32'h71c302a0;
	int          num_errors = 0;
	int          tests_run  = 0;
	int          alt_ctr    = 0;
	logic [31:0] rdata, d, cen, v, sx;
	logic [23:0] synth_frac;
	logic [7:0]  pa_level, rx_bw;
	logic        tx_data_in, bit_clock_out, rx_data_out;
	int          n, m;

	fom_datapath fom_datapath_inst (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
		.rf(rf), .tx_data_in(tx_data_in), .synth_frac(synth_frac), .pa_level(pa_level),
		.rx_bw(rx_bw), .bit_clock_out(bit_clock_out), .rx_data_out(rx_data_out));
	fom_mcu_model fom_mcu_model_inst (.core_clk(core_clk), .rst(rst),
		.bit_clock_out(bit_clock_out), .pattern(pattern), .tx_data_in(tx_data_in));

	always #4 core_clk = ~core_clk;

	// received alternating preamble at the programmed rate
	always @(posedge core_clk) begin
		if (rx_alt) begin
			alt_ctr <= (alt_ctr == rate - 1) ? 0 : alt_ctr + 1;
			if (alt_ctr == rate - 1)
				rf.fsk_bit <= ~rf.fsk_bit;
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		bus.addr  <= a;
		bus.wdata <= wd;
		bus.wr    <= 1'b1;
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge core_clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge core_clk);
		bus.rd <= 1'b0;
		@(negedge core_clk);
		q = rdata;
	endtask

	task automatic results();
		$display("mismatches %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// cycles up to the next rise of bit_clock_out
	task automatic gap(output int cnt);
		logic prev;
		prev = bit_clock_out;
		for (cnt = 1; cnt < 4000; cnt++) begin
			@(negedge core_clk);
			if (bit_clock_out && !prev)
				break;
			prev = bit_clock_out;
		end
		if (cnt >= 4000) begin
			num_errors++;
			results();
		end
	endtask

	// cycles up to the next change of the synthesizer word
	task automatic chg(output int cnt);
		logic [23:0] old;
		old = synth_frac;
		for (cnt = 1; cnt < 4000 && synth_frac === old; cnt++)
			@(negedge core_clk);
		if (cnt >= 4000) begin
			num_errors++;
			results();
		end
	endtask

	task automatic slice(input logic [7:0] r, input logic e);
		@(posedge core_clk);
		rf.rssi <= r;
		repeat (4) @(negedge core_clk);
		chk({31'h0, rx_data_out}, {31'h0, e});
	endtask

	task automatic inrange(input int x, input int lo, input int hi);
		chk({31'h0, x >= lo && x <= hi}, 32'h1);
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(`FOM_OFF_RATE, d);
		chk(d, {12'h0, `FOM_RATE_RST});
		rd(`FOM_OFF_DEV, d);
		chk(d, {18'h0, `FOM_DEV_RST});
		rd(`FOM_OFF_CARRIER, d);
		chk(d, {8'h0, `FOM_CARRIER_RST});
		wr(8'h3c, 32'hffffffff);
		rd(8'h3c, d);
		chk(d, 32'h0);
		$display("reset and map test done");

		wr(`FOM_OFF_RATE, {12'h0, 16'd500, 4'h0});
		wr(`FOM_OFF_RXCFG, 32'h10);
		for (int i = 0; i < 3; i++) begin
			v   = 32'd10 + rnd() % 32'd1800;
			cen = 32'h100000 + rnd() % 32'he00000;
			wr(`FOM_OFF_DEV, v);
			wr(`FOM_OFF_CARRIER, cen);
			rd(`FOM_OFF_DEV, d);
			chk(d, v);
			@(posedge core_clk);
			rf.tx_mode <= 1'b1;
			pattern    <= 2'h1;
			repeat (3 * rate) @(negedge core_clk);
			chk({8'h0, synth_frac}, cen + v);
			@(posedge core_clk);
			pattern <= 2'h2;
			repeat (3 * rate) @(negedge core_clk);
			chk({8'h0, synth_frac}, cen - v);
		end
		$display("deviation test done");

		for (int s = 1; s < 3; s++) begin
			@(posedge core_clk);
			rf.tx_mode <= 1'b0;
			wr(`FOM_OFF_SHAPE, s);
			@(posedge core_clk);
			rf.tx_mode <= 1'b1;
			pattern    <= 2'h0;
			gap(n);
			gap(n);
			chk(n, rate);
			@(negedge core_clk);
			chk({31'h0, bit_clock_out}, 32'h0);
			inrange({8'h0, synth_frac}, cen - v, cen + v);
		end
		wr(`FOM_OFF_RATE, {12'h0, 16'd500, 4'h8});
		gap(n);
		gap(n);
		gap(m);
		chk(n + m, 2 * rate + 1);
		@(posedge core_clk);
		rf.ook_mode <= 1'b1;
		gap(n);
		gap(n);
		chk(n, rate);
		$display("bit clock test done");

		@(posedge core_clk);
		rf.tx_mode <= 1'b0;
		wr(`FOM_OFF_SHAPE, 32'h0);
		@(posedge core_clk);
		rf.tx_mode <= 1'b1;
		pattern    <= 2'h1;
		repeat (3 * rate) @(negedge core_clk);
		chk({24'h0, pa_level}, 32'hff);
		@(posedge core_clk);
		pattern <= 2'h2;
		repeat (3 * rate) @(negedge core_clk);
		chk({24'h0, pa_level}, 32'h00);
		@(posedge core_clk);
		rf.tx_mode <= 1'b0;
		wr(`FOM_OFF_SHAPE, 32'h1);
		@(posedge core_clk);
		rf.tx_mode <= 1'b1;
		pattern    <= 2'h1;
		for (n = 0; n < 2000 && pa_level !== 8'h80; n++)
			@(negedge core_clk);
		if (n >= 2000) begin
			num_errors++;
			results();
		end
		repeat (16) @(negedge core_clk);
		chk({24'h0, pa_level}, 32'h90);
		$display("amplifier keying test done");

		@(posedge core_clk);
		rf.tx_mode <= 1'b0;
		rf.rx_mode <= 1'b1;
		wr(`FOM_OFF_RXCFG, 32'h18);
		wr(`FOM_OFF_OOK, 32'h0040);
		slice(8'h50, 1'b1);
		slice(8'h30, 1'b0);
		wr(`FOM_OFF_OOK, 32'h4740);
		slice(8'h80, 1'b1);
		slice(8'h78, 1'b1);
		slice(8'h70, 1'b0);
		slice(8'h00, 1'b0);
		repeat (10 * rate) @(posedge core_clk);
		rd(`FOM_OFF_STATUS, d);
		chk({24'h0, d[15:8]}, 32'h40);
		wr(`FOM_OFF_OOK, 32'h8040);
		slice(8'h60, 1'b1);
		repeat (2 * rate) @(posedge core_clk);
		slice(8'ha0, 1'b1);
		slice(8'h20, 1'b0);
		$display("slicer test done");

		@(posedge core_clk);
		rf.ook_mode <= 1'b0;
		rx_alt      <= 1'b1;
		wr(`FOM_OFF_RXCFG, 32'h10);
		repeat (4) gap(n);
		inrange(n, rate - 10, rate + 10);
		// alternating preamble: retimed data is inverted one bit later
		d = {31'h0, rx_data_out};
		repeat (rate) @(negedge core_clk);
		chk({31'h0, rx_data_out}, {31'h0, ~d[0]});
		wr(`FOM_OFF_RXCFG, 32'h18);
		repeat (rate) @(negedge core_clk);
		m = 0;
		repeat (3 * rate) begin
			@(negedge core_clk);
			m += bit_clock_out;
		end
		chk(m, 0);
		@(posedge core_clk);
		rf.packet_mode <= 1'b1;
		repeat (4) gap(n);
		inrange(n, rate - 10, rate + 10);
		@(posedge core_clk);
		rf.packet_mode <= 1'b0;
		rx_alt         <= 1'b0;
		rf.rx_mode     <= 1'b0;
		$display("bit sync test done");

		for (int g = 0; g < 3; g++) begin
			v   = rnd() | 32'h1;
			sx  = {{24{v[7]}}, v[7:0]};
			cen = 32'h100000 + rnd() % 32'he00000;
			@(posedge core_clk);
			rf.rx_mode             <= 1'b0;
			rf.freq_disc           <= v[7:0];
			rf.preamble_found_flag <= 1'b0;
			wr(`FOM_OFF_RXCFG, (g == 0) ? 32'h1 : (g == 1) ? 32'h3 : 32'h5);
			wr(`FOM_OFF_BW, 32'h3322);
			wr(`FOM_OFF_CARRIER, cen);
			@(posedge core_clk);
			rf.rx_mode <= 1'b1;
			repeat (3) @(negedge core_clk);
			chk({24'h0, rx_bw}, 32'h33);
			if (g == 2) begin
				repeat (6 * rate) @(negedge core_clk);
				chk({8'h0, synth_frac}, cen);
				@(posedge core_clk);
				rf.preamble_found_flag <= 1'b1;
			end
			chg(n);
			if (g == 0)
				inrange(n, 3 * rate, 5 * rate);
			chk({8'h0, synth_frac}, (cen - sx) & 32'hffffff);
			chk({24'h0, rx_bw}, 32'h22);
			rd(`FOM_OFF_FEI, d);
			chk({16'h0, d[15:0]}, {16'h0, sx[15:0]});
			if (g == 0) begin
				chg(n);
				inrange(n, 3 * rate, 5 * rate);
				chk({8'h0, synth_frac}, (cen - 2 * sx) & 32'hffffff);
			end else if (g == 1) begin
				repeat (5 * rate) @(negedge core_clk);
				chk({8'h0, synth_frac}, (cen - sx) & 32'hffffff);
			end
		end
		$display("frequency correction test done");
		results();
	end
endmodule // fom_datapath_test
